// >>> bench/dsrw_bus_assertions.sv
/*
 * Checker for the data-space bus between the core end and the decoding end.
 * Assumes it is instantiated beside the bus interface with one clock.
 */
`timescale 1ns/1ps
module dsrw_bus_assertions (
   input wire logic                 clk,
   input wire logic                 reset_n,
   input wire dsrw_pkg::dsrw_addr_t addr,
   input wire dsrw_pkg::dsrw_byte_t wdata,
   input wire logic                 wr,
   input wire logic                 rd,
   input wire dsrw_pkg::dsrw_pc_t   pc,
   input wire dsrw_pkg::dsrw_byte_t rdata,
   input wire logic                 rvalid,
   input wire dsrw_pkg::dsrw_byte_t fetch_data
);
   import dsrw_pkg::*;
   logic       loaded_q;
   dsrw_byte_t tpre_q;
   logic       win;

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // A window read is only legal once the select has been written.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         loaded_q <= 1'b0;
      end else if (wr && addr == DSRW_OFS_WSEL) begin
         loaded_q <= 1'b1;
      end
   end

   // Shadow of the prescaler so readback can be judged across many cycles.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tpre_q <= DSRW_RST_TPRE;
      end else if (wr && addr == DSRW_OFS_TPRE) begin
         tpre_q <= wdata;
      end
   end

   assign win = rd && addr >= DSRW_WIN_LO && addr <= DSRW_WIN_HI;

   read_answer_a: assert property (rd |=> rvalid)
      else $error("read not answered next cycle");
   answer_cause_a: assert property (rvalid |-> $past(rd))
      else $error("answer without a read");
   window_loaded_a: assert property (win |-> loaded_q)
      else $error("window read before select load");
   select_top_a: assert property (wr && addr == DSRW_OFS_WSEL |-> wdata[7:6] == 2'b00)
      else $error("select written with top bits set");
   select_unread_a: assert property (rd |-> addr != DSRW_OFS_WSEL)
      else $error("select register read on bus");
   reserved_zero_a: assert property (rd && addr inside {8'hc2, 8'hc8, 8'hd5}
      |=> rdata == DSRW_UNDEF_RD)
      else $error("reserved read not zero");
   prescaler_rw_a: assert property (rd && addr == DSRW_OFS_TPRE |=> rdata == tpre_q)
      else $error("prescaler readback wrong");
   fetch_hold_a: assert property (win |=> $stable(fetch_data))
      else $error("fetch changed during window read");
endmodule

// >>> bench/test_data_space_rom_window_decode.sv
/*
 * Self-checking bench joining the core end and the decoding end.
 * Assumes a combinational program memory modelled here from pm_addr.
 */
`timescale 1ns/1ps
module test_data_space_rom_window_decode;
   import dsrw_pkg::*;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       req_valid = 1'b0;
   logic       req_write = 1'b0;
   dsrw_addr_t req_addr = 8'h00;
   dsrw_byte_t req_wdata = 8'h00;
   dsrw_pc_t   pc_in = 12'h9a5;
   dsrw_byte_t pin_a_in = 8'h3c;
   dsrw_byte_t pin_b_in = 8'h99;
   dsrw_byte_t converter_result = 8'h00;
   logic       converter_done = 1'b0;
   logic       req_ready, resp_valid, req_refused;
   dsrw_byte_t resp_data, fetch_out, pm_rdata, port_a_out, port_a_oe;
   dsrw_byte_t converter_control, timer_prescaler;
   dsrw_byte_t port_b_out, port_b_oe, port_a_option, port_b_option, interrupt_option;
   dsrw_byte_t timer_downcounter, timer_status_control, watchdog_counter;
   dsrw_pc_t   pm_addr;
   int         fails = 0;
   int         checked = 0;

   // Program memory pattern differs per block, so a wrong block shows.
   function automatic dsrw_byte_t pm(input dsrw_pc_t a);
      return a[11:4] ^ a[7:0];
   endfunction
   assign pm_rdata = pm(pm_addr);

   always #5 clk = ~clk;

   dsrw_bus_if dsrw_bus_if_inst (.clk(clk), .reset_n(reset_n));
   dsrw_core dsrw_core_inst (.bus(dsrw_bus_if_inst), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .pc_in(pc_in),
      .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
      .req_refused(req_refused), .fetch_out(fetch_out));
   dsrw_dev dsrw_dev_inst (.bus(dsrw_bus_if_inst), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
      .pin_a_in(pin_a_in), .pin_b_in(pin_b_in), .port_a_out(port_a_out),
      .port_a_oe(port_a_oe), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
      .port_a_option(port_a_option), .port_b_option(port_b_option),
      .interrupt_option(interrupt_option), .converter_result(converter_result),
      .converter_done(converter_done), .converter_control(converter_control),
      .timer_prescaler(timer_prescaler), .timer_downcounter(timer_downcounter),
      .timer_status_control(timer_status_control), .watchdog_counter(watchdog_counter));
   dsrw_bus_assertions dsrw_bus_assertions_inst (.clk(clk), .reset_n(reset_n),
      .addr(dsrw_bus_if_inst.addr), .wdata(dsrw_bus_if_inst.wdata), .wr(dsrw_bus_if_inst.wr),
      .rd(dsrw_bus_if_inst.rd), .pc(dsrw_bus_if_inst.pc), .rdata(dsrw_bus_if_inst.rdata),
      .rvalid(dsrw_bus_if_inst.rvalid), .fetch_data(dsrw_bus_if_inst.fetch_data));

   task automatic cmp8(input string name, input dsrw_byte_t exp, input dsrw_byte_t got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cmp1(input string name, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic finish_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One request; an idle edge first keeps strobes from being set twice in a step.
   task automatic go(input logic w, input dsrw_addr_t a, input dsrw_byte_t d);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      while (req_ready !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 20) begin
            fails++;
            finish_test();
         end
      end
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
   endtask

   task automatic rd(input string name, input dsrw_addr_t a, input dsrw_byte_t exp);
      int n;
      go(1'b0, a, 8'h00);
      n = 0;
      while (resp_valid !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (resp_valid !== 1'b1) begin
         fails++;
         finish_test();
      end
      cmp8(name, exp, resp_data);
   endtask

   task automatic t_reset;
      cmp8("prescaler_out", DSRW_RST_TPRE, timer_prescaler);
      cmp8("conv_ctl_out", DSRW_RST_CCTL, converter_control);
      cmp8("tcnt_out", DSRW_RST_TCNT, timer_downcounter);
      cmp8("tsc_out", DSRW_RST_TSC, timer_status_control);
      cmp8("port_b_rst", DSRW_RST_PORT, port_b_out);
      cmp8("opt_b_out", DSRW_RST_PORT, port_b_option);
      rd("dir_a", DSRW_OFS_DIRA, 8'h00);
      rd("opt_b", DSRW_OFS_OPTB, 8'h00);
      rd("tcnt", DSRW_OFS_TCNT, 8'hff);
      rd("tsc", DSRW_OFS_TSC, 8'h00);
      rd("port_a_pins", DSRW_OFS_PDA, pin_a_in);
      go(1'b0, 8'h45, 8'h00);
      cmp1("early_window", 1'b1, req_refused);
      cmp8("fetch", pm(pc_in), fetch_out);
      // A fetch near the top of program space exercises the upper six counter bits, 11:6.
      pc_in = 12'hfc3;
      @(posedge clk);
      #1;
      cmp8("fetch_top", pm(12'hfc3), fetch_out);
      $display("test reset done");
   endtask

   task automatic t_window;
      dsrw_byte_t blk[4] = '{8'h00, 8'h01, 8'h03, 8'h3f};
      for (int i = 0; i < 4; i++) begin
         go(1'b1, DSRW_OFS_WSEL, blk[i]);
         rd("win_lo", 8'h40, pm({blk[i][5:0], 6'h00}));
         rd("win_hi", 8'h7f, pm({blk[i][5:0], 6'h3f}));
      end
      // Top bits set by software must not move the window off block 5.
      go(1'b1, DSRW_OFS_WSEL, 8'hc5);
      rd("win_mid", 8'h55, pm(12'h155));
      $display("test window done");
   endtask

   task automatic t_ports;
      go(1'b1, DSRW_OFS_DIRA, 8'h0f);
      go(1'b1, DSRW_OFS_PDA, 8'h0a);
      pin_a_in = 8'hc3;
      cmp8("port_a_out", 8'h0a, port_a_out);
      cmp8("port_a_oe", 8'h0f, port_a_oe);
      rd("port_a_mix", DSRW_OFS_PDA, 8'hca);
      go(1'b1, DSRW_OFS_PDB, 8'ha5);
      go(1'b1, DSRW_OFS_DIRB, 8'hff);
      rd("port_b_out", DSRW_OFS_PDB, 8'ha5);
      cmp8("port_b_pins", 8'ha5, port_b_out);
      cmp8("port_b_oe", 8'hff, port_b_oe);
      go(1'b1, DSRW_OFS_OPTA, 8'h03);
      rd("opt_a", DSRW_OFS_OPTA, 8'h03);
      cmp8("opt_a_out", 8'h03, port_a_option);
      $display("test ports done");
   endtask

   task automatic t_reserved;
      // Reserved writes that alias live registers in their low bits.
      go(1'b1, 8'h82, 8'h3c);
      go(1'b1, DSRW_OFS_ACC, 8'hc6);
      go(1'b1, 8'hc2, 8'hff);
      go(1'b1, 8'hfe, 8'h00);
      go(1'b1, 8'hd9, 8'h00);
      go(1'b1, DSRW_OFS_IOPT, 8'h55);
      cmp8("iopt_out", 8'h55, interrupt_option);
      cmp8("wdog_kept", DSRW_RST_WDOG, watchdog_counter);
      rd("cpu_kept", 8'h82, 8'h3c);
      rd("acc_kept", DSRW_OFS_ACC, 8'hc6);
      rd("resv_c2", 8'hc2, DSRW_UNDEF_RD);
      rd("iopt_rd", DSRW_OFS_IOPT, DSRW_UNDEF_RD);
      rd("resv_d5", 8'hd5, DSRW_UNDEF_RD);
      converter_result = 8'h6e;
      go(1'b1, DSRW_OFS_CRES, 8'hff);
      rd("conv_res", DSRW_OFS_CRES, 8'h6e);
      go(1'b1, DSRW_OFS_CCTL, 8'hff);
      cmp8("conv_ctl_wr", 8'h7f, converter_control);
      converter_done = 1'b1;
      rd("conv_ctl_rd", DSRW_OFS_CCTL, 8'h80);
      go(1'b1, DSRW_OFS_TPRE, 8'h12);
      rd("tpre_rw", DSRW_OFS_TPRE, 8'h12);
      rd("dir_a_kept", DSRW_OFS_DIRA, 8'h0f);
      rd("select_image", DSRW_OFS_WSEL, 8'h05);
      $display("test reserved done");
   endtask

   initial begin
      repeat (6) @(posedge clk);
      #1;
      reset_n = 1'b1;
      t_reset();
      t_window();
      t_ports();
      t_reserved();
      finish_test();
   end
endmodule

// >>> hw/dsrw_core.sv
/*
 * Core end of the data-space bus: turns user requests into bus strobes and
 * keeps the software-side duties for the write-only window select.
 * Assumes the decoding end answers a read exactly one cycle after rd.
 */
`timescale 1ns/1ps
module dsrw_core (
   dsrw_bus_if.core              bus,
   input  wire logic             req_valid,
   input  wire logic             req_write,
   input  wire dsrw_pkg::dsrw_addr_t req_addr,
   input  wire dsrw_pkg::dsrw_byte_t req_wdata,
   input  wire dsrw_pkg::dsrw_pc_t   pc_in,
   output logic                  req_ready,
   output logic                  resp_valid,
   output dsrw_pkg::dsrw_byte_t  resp_data,
   output logic                  req_refused,
   output dsrw_pkg::dsrw_byte_t  fetch_out
);
   import dsrw_pkg::*;

   typedef enum logic [1:0] {
      DSRW_IDLE = 2'b01,
      DSRW_WAIT = 2'b10
   } dsrw_state_t;

   dsrw_state_t                  state_q;
   dsrw_byte_t                   image_q, resp_q;
   logic                         loaded_q, resp_valid_q, refused_q;
   logic                         is_win, is_wsel, refuse, local_rd, take;

   assign is_win   = (req_addr >= DSRW_WIN_LO) && (req_addr <= DSRW_WIN_HI);
   assign is_wsel  = (req_addr == DSRW_OFS_WSEL);
   // The select register is never read; its RAM image answers instead.
   assign local_rd = !req_write && is_wsel; // see RL8 see RL9
   // Window reads before the first select load would return garbage.
   assign refuse   = !req_write && is_win && !loaded_q; // see RL7
   assign take     = req_valid && (state_q == DSRW_IDLE);
   assign req_ready = (state_q == DSRW_IDLE);

   // Bus strobes; a write to the select register has bits 7:6 forced low.
   assign bus.addr  = req_addr;
   assign bus.wdata = is_wsel ? {2'b00, req_wdata[DSRW_WSEL_MSB:0]} : req_wdata; // see RL6
   assign bus.wr    = take && req_write;
   assign bus.rd    = take && !req_write && !local_rd && !refuse;
   assign bus.pc    = pc_in;

   // Sequencer: one bus read in flight at a time.
   always_ff @(posedge bus.clk or negedge bus.reset_n) begin
      if (!bus.reset_n) begin
         state_q <= DSRW_IDLE;
      end else begin
         case (state_q)
            DSRW_IDLE: begin
               if (bus.rd) begin
                  state_q <= DSRW_WAIT;
               end
            end
            DSRW_WAIT: begin
               if (bus.rvalid) begin
                  state_q <= DSRW_IDLE;
               end
            end
            default: begin
               state_q <= DSRW_IDLE;
            end
         endcase
      end
   end

   // Image is updated in the same cycle as the bus write, so an interrupt
   // can never see, once the select is loaded, a select value that its image does not match.
   always_ff @(posedge bus.clk or negedge bus.reset_n) begin
      if (!bus.reset_n) begin
         image_q  <= DSRW_UNDEF_RD;
         loaded_q <= 1'b0;
      end else if (bus.wr && is_wsel) begin
         image_q  <= {2'b00, req_wdata[DSRW_WSEL_MSB:0]}; // see RL9
         loaded_q <= 1'b1; // see RL7
      end
   end

   // Answers: bus read data, the local image, or a refusal pulse.
   always_ff @(posedge bus.clk or negedge bus.reset_n) begin
      if (!bus.reset_n) begin
         resp_q       <= DSRW_UNDEF_RD;
         resp_valid_q <= 1'b0;
         refused_q    <= 1'b0;
      end else begin
         resp_valid_q <= (state_q == DSRW_WAIT && bus.rvalid) || (take && local_rd);
         refused_q    <= take && refuse;
         if (state_q == DSRW_WAIT && bus.rvalid) begin
            resp_q <= bus.rdata;
         end else if (take && local_rd) begin
            resp_q <= image_q;
         end
      end
   end

   assign resp_valid  = resp_valid_q;
   assign resp_data   = resp_q;
   assign req_refused = refused_q;
   assign fetch_out   = bus.fetch_data;
endmodule

// >>> hw/dsrw_dev.sv
/*
 * Decoding end of the data-space bus: the register map, the port data
 * readback and the read-only window onto program memory.
 * Assumes the program memory answers combinationally on pm_rdata for the
 * address on pm_addr, and that pin inputs are synchronous to clk.
 */
// Rules for this block and the software that uses it
// RL1 - 0040h to 007Fh decode as program-memory window.
// RL2 - Window read returns one of 64 bytes.
// RL3 - Block n covers n*64 to n*64+63.
// RL4 - Select bits 5:0 give upper address bits.
// RL5 - Low six address bits give block offset.
// RL6 - Software writes zero to select bits 7:6.
// RL7 - Select register not reset; load before use.
// RL8 - Select is write-only at 0C9h; never read.
// RL9 - Interrupt handlers keep a RAM image first. The core updates its image in the same cycle as the select, not before it.
// RL10 - Port data reads: outputs stored, inputs live.
// RL11 - Software keeps absent pin bits at reset.
// RL12 - No bit instructions on ports with inputs.
// RL13 - Port data, direction, option reset 00h, RW.
// RL14 - Converter control resets 40h; result read-only.
// RL15 - Timer registers reset 7Fh, 0FFh, 00h, RW.
// RL16 - Reserved accesses disturb nothing, read undefined.
// RL17 - Program counter is 12 bits, 4K space.
`timescale 1ns/1ps
module dsrw_dev (
   dsrw_bus_if.dev          bus,
   output dsrw_pkg::dsrw_pc_t   pm_addr,
   input  wire dsrw_pkg::dsrw_byte_t pm_rdata,
   input  wire dsrw_pkg::dsrw_byte_t pin_a_in,
   input  wire dsrw_pkg::dsrw_byte_t pin_b_in,
   output dsrw_pkg::dsrw_byte_t port_a_out,
   output dsrw_pkg::dsrw_byte_t port_a_oe,
   output dsrw_pkg::dsrw_byte_t port_b_out,
   output dsrw_pkg::dsrw_byte_t port_b_oe,
   output dsrw_pkg::dsrw_byte_t port_a_option,
   output dsrw_pkg::dsrw_byte_t port_b_option,
   output dsrw_pkg::dsrw_byte_t interrupt_option,
   input  wire dsrw_pkg::dsrw_byte_t converter_result,
   input  wire logic            converter_done,
   output dsrw_pkg::dsrw_byte_t converter_control,
   output dsrw_pkg::dsrw_byte_t timer_prescaler,
   output dsrw_pkg::dsrw_byte_t timer_downcounter,
   output dsrw_pkg::dsrw_byte_t timer_status_control,
   output dsrw_pkg::dsrw_byte_t watchdog_counter
);
   import dsrw_pkg::*;

   dsrw_byte_t                 pda_q, pdb_q, dira_q, dirb_q, opta_q, optb_q;
   dsrw_byte_t                 iopt_q, cctl_q, tpre_q, tcnt_q, tsc_q, wdog_q;
   logic [DSRW_WSEL_MSB:0]     wsel_q;
   dsrw_byte_t                 cpu_q [4];
   dsrw_byte_t                 acc_q;
   dsrw_byte_t                 rdata_q, rdata_d, fetch_q;
   logic                       rvalid_q;
   logic                       in_win;

   // Port readback: direction high means the stored value drives the pin.
   function automatic dsrw_byte_t port_read(input dsrw_byte_t data,
                                            input dsrw_byte_t dir,
                                            input dsrw_byte_t pin);
      port_read = (data & dir) | (pin & ~dir); // see RL10
   endfunction

   // Write strobe for one offset, used by every register but the cpu_q bank.
   function automatic logic hit(input dsrw_addr_t ofs);
      hit = bus.wr && (bus.addr == ofs);
   endfunction

   // Window decode covers exactly 40h..7Fh of the data space.
   assign in_win = (bus.addr >= DSRW_WIN_LO) && (bus.addr <= DSRW_WIN_HI); // see RL1

   // The shared program-memory port serves window reads first, else fetch.
   // A window read thus steals one fetch cycle; fetch_q keeps its previous byte for that cycle.
   always_comb begin
      if (bus.rd && in_win) begin
         pm_addr = {wsel_q, bus.addr[DSRW_OFSW-1:0]}; // see RL3 see RL4 see RL5
      end else begin
         pm_addr = bus.pc; // see RL17
      end
   end

   // Port data, direction and option registers, all cleared at reset.
   always_ff @(posedge bus.clk or negedge bus.reset_n) begin
      if (!bus.reset_n) begin
         pda_q  <= DSRW_RST_PORT; // see RL13
         pdb_q  <= DSRW_RST_PORT;
         dira_q <= DSRW_RST_PORT;
         dirb_q <= DSRW_RST_PORT;
         opta_q <= DSRW_RST_PORT;
         optb_q <= DSRW_RST_PORT;
      end else begin
         if (hit(DSRW_OFS_PDA)) begin
            pda_q <= bus.wdata;
         end
         if (hit(DSRW_OFS_PDB)) begin
            pdb_q <= bus.wdata;
         end
         if (hit(DSRW_OFS_DIRA)) begin
            dira_q <= bus.wdata;
         end
         if (hit(DSRW_OFS_DIRB)) begin
            dirb_q <= bus.wdata;
         end
         if (hit(DSRW_OFS_OPTA)) begin
            opta_q <= bus.wdata;
         end
         if (hit(DSRW_OFS_OPTB)) begin
            optb_q <= bus.wdata;
         end
      end
   end

   // Converter, timer and watchdog registers with their own reset values.
   always_ff @(posedge bus.clk or negedge bus.reset_n) begin
      if (!bus.reset_n) begin
         cctl_q <= DSRW_RST_CCTL; // see RL14
         tpre_q <= DSRW_RST_TPRE; // see RL15
         tcnt_q <= DSRW_RST_TCNT;
         tsc_q  <= DSRW_RST_TSC;
         wdog_q <= DSRW_RST_WDOG;
      end else begin
         if (hit(DSRW_OFS_CCTL)) begin
            cctl_q <= bus.wdata & ~DSRW_CCTL_RO; // see RL14
         end
         if (hit(DSRW_OFS_TPRE)) begin
            tpre_q <= bus.wdata;
         end
         if (hit(DSRW_OFS_TCNT)) begin
            tcnt_q <= bus.wdata;
         end
         if (hit(DSRW_OFS_TSC)) begin
            tsc_q <= bus.wdata;
         end
         if (hit(DSRW_OFS_WDOG)) begin
            wdog_q <= bus.wdata;
         end
      end
   end

   // Registers that hold whatever power-up left in them, so no reset term.
   // The window select keeps only its six block bits; 7:6 are dropped.
   always_ff @(posedge bus.clk) begin
      if (hit(DSRW_OFS_WSEL)) begin
         wsel_q <= bus.wdata[DSRW_WSEL_MSB:0]; // see RL7 see RL8 see RL2
      end
      if (hit(DSRW_OFS_IOPT)) begin
         iopt_q <= bus.wdata;
      end
      if (bus.wr && (bus.addr >= DSRW_OFS_IDX1) && (bus.addr <= DSRW_OFS_SDR2)) begin
         cpu_q[bus.addr[1:0]] <= bus.wdata;
      end
      if (hit(DSRW_OFS_ACC)) begin
         acc_q <= bus.wdata;
      end
   end

   // Read multiplexer; write-only and reserved locations give a fixed value.
   always_comb begin
      rdata_d = DSRW_UNDEF_RD; // see RL16
      if (in_win) begin
         rdata_d = pm_rdata; // see RL2
      end else if ((bus.addr >= DSRW_OFS_IDX1) && (bus.addr <= DSRW_OFS_SDR2)) begin
         rdata_d = cpu_q[bus.addr[1:0]];
      end else if (bus.addr == DSRW_OFS_PDA) begin
         rdata_d = port_read(pda_q, dira_q, pin_a_in);
      end else if (bus.addr == DSRW_OFS_PDB) begin
         rdata_d = port_read(pdb_q, dirb_q, pin_b_in);
      end else if (bus.addr == DSRW_OFS_DIRA) begin
         rdata_d = dira_q;
      end else if (bus.addr == DSRW_OFS_DIRB) begin
         rdata_d = dirb_q;
      end else if (bus.addr == DSRW_OFS_OPTA) begin
         rdata_d = opta_q;
      end else if (bus.addr == DSRW_OFS_OPTB) begin
         rdata_d = optb_q;
      end else if (bus.addr == DSRW_OFS_CRES) begin
         rdata_d = converter_result; // see RL14
      end else if (bus.addr == DSRW_OFS_CCTL) begin
         rdata_d = {converter_done, 7'h00} & DSRW_CCTL_RO; // see RL14
      end else if (bus.addr == DSRW_OFS_TPRE) begin
         rdata_d = tpre_q;
      end else if (bus.addr == DSRW_OFS_TCNT) begin
         rdata_d = tcnt_q;
      end else if (bus.addr == DSRW_OFS_TSC) begin
         rdata_d = tsc_q;
      end else if (bus.addr == DSRW_OFS_WDOG) begin
         rdata_d = wdog_q;
      end else if (bus.addr == DSRW_OFS_ACC) begin
         rdata_d = acc_q;
      end
   end

   // Answer and fetch registers; fetch data holds while a window read runs.
   always_ff @(posedge bus.clk or negedge bus.reset_n) begin
      if (!bus.reset_n) begin
         rdata_q  <= DSRW_UNDEF_RD;
         rvalid_q <= 1'b0;
         fetch_q  <= DSRW_UNDEF_RD;
      end else begin
         rvalid_q <= bus.rd;
         if (bus.rd) begin
            rdata_q <= rdata_d;
         end
         if (!(bus.rd && in_win)) begin
            fetch_q <= pm_rdata;
         end
      end
   end

   assign bus.rdata            = rdata_q;
   assign bus.rvalid           = rvalid_q;
   assign bus.fetch_data       = fetch_q;
   assign port_a_out           = pda_q;
   assign port_a_oe            = dira_q;
   assign port_b_out           = pdb_q;
   assign port_b_oe            = dirb_q;
   assign port_a_option        = opta_q;
   assign port_b_option        = optb_q;
   assign interrupt_option     = iopt_q;
   assign converter_control    = cctl_q;
   assign timer_prescaler      = tpre_q;
   assign timer_downcounter    = tcnt_q;
   assign timer_status_control = tsc_q;
   assign watchdog_counter     = wdog_q;
endmodule

// >>> inc/dsrw_bus_if.sv
/*
 * Data-space bus between the processor core end and the decoding end.
 * Assumes one clock and one asynchronous active-low reset for both ends.
 */
`timescale 1ns/1ps
interface dsrw_bus_if (
   input wire logic clk,
   input wire logic reset_n
);
   import dsrw_pkg::*;

   dsrw_addr_t  addr;       // Data-space address, core driven.
   dsrw_byte_t  wdata;      // Write data, core driven.
   logic        wr;         // One-cycle write strobe.
   logic        rd;         // One-cycle read strobe.
   dsrw_pc_t    pc;         // Program counter for instruction fetch.
   dsrw_byte_t  rdata;      // Read answer, registered.
   logic        rvalid;     // One-cycle answer strobe.
   dsrw_byte_t  fetch_data; // Fetched program byte, registered.

   modport core (
      input  clk, reset_n, rdata, rvalid, fetch_data,
      output addr, wdata, wr, rd, pc
   );
   modport dev (
      input  clk, reset_n, addr, wdata, wr, rd, pc,
      output rdata, rvalid, fetch_data
   );
endinterface

// >>> inc/dsrw_pkg.sv
/*
 * Constants shared by both ends of the data-space bus: register offsets,
 * reset values, window geometry and field positions.
 * Assumes an 8-bit data space and a 12-bit program space.
 */
package dsrw_pkg;
   localparam int          DSRW_DW        = 8;
   localparam int          DSRW_AW        = 8;
   localparam int          DSRW_PCW       = 12;
   localparam int          DSRW_BLKW      = 6;
   localparam int          DSRW_OFSW      = 6;

   typedef logic [DSRW_DW-1:0]  dsrw_byte_t;
   typedef logic [DSRW_AW-1:0]  dsrw_addr_t;
   typedef logic [DSRW_PCW-1:0] dsrw_pc_t;

   // Read-only window onto program memory.
   localparam dsrw_addr_t  DSRW_WIN_LO    = 8'h40;
   localparam dsrw_addr_t  DSRW_WIN_HI    = 8'h7f;

   // Register offsets.
   localparam dsrw_addr_t  DSRW_OFS_IDX1  = 8'h80;
   localparam dsrw_addr_t  DSRW_OFS_SDR2  = 8'h83;
   localparam dsrw_addr_t  DSRW_OFS_PDA   = 8'hc0;
   localparam dsrw_addr_t  DSRW_OFS_PDB   = 8'hc1;
   localparam dsrw_addr_t  DSRW_OFS_DIRA  = 8'hc4;
   localparam dsrw_addr_t  DSRW_OFS_DIRB  = 8'hc5;
   localparam dsrw_addr_t  DSRW_OFS_IOPT  = 8'hc8;
   localparam dsrw_addr_t  DSRW_OFS_WSEL  = 8'hc9;
   localparam dsrw_addr_t  DSRW_OFS_OPTA  = 8'hcc;
   localparam dsrw_addr_t  DSRW_OFS_OPTB  = 8'hcd;
   localparam dsrw_addr_t  DSRW_OFS_CRES  = 8'hd0;
   localparam dsrw_addr_t  DSRW_OFS_CCTL  = 8'hd1;
   localparam dsrw_addr_t  DSRW_OFS_TPRE  = 8'hd2;
   localparam dsrw_addr_t  DSRW_OFS_TCNT  = 8'hd3;
   localparam dsrw_addr_t  DSRW_OFS_TSC   = 8'hd4;
   localparam dsrw_addr_t  DSRW_OFS_WDOG  = 8'hd8;
   localparam dsrw_addr_t  DSRW_OFS_ACC   = 8'hff;

   // Reset values.
   localparam dsrw_byte_t  DSRW_RST_PORT  = 8'h00;
   localparam dsrw_byte_t  DSRW_RST_CCTL  = 8'h40;
   localparam dsrw_byte_t  DSRW_RST_TPRE  = 8'h7f;
   localparam dsrw_byte_t  DSRW_RST_TCNT  = 8'hff;
   localparam dsrw_byte_t  DSRW_RST_TSC   = 8'h00;
   localparam dsrw_byte_t  DSRW_RST_WDOG  = 8'hfe;

   // Converter control bits that read from hardware; the rest are write-only.
   localparam dsrw_byte_t  DSRW_CCTL_RO   = 8'h80;
   // Value returned by undefined reads (write-only and reserved locations).
   localparam dsrw_byte_t  DSRW_UNDEF_RD  = 8'h00;
   // Window select field position.
   localparam int          DSRW_WSEL_MSB  = 5;
endpackage
